// ---- rtl/darc_pkg.sv ----
package darc_pkg;
  // ==========================================================================
  // Frame layout
  localparam int FRAME_BITS = 24;
  localparam int CMD_MSB = 23;
  localparam int CMD_LSB = 20;
  localparam int ADDR_MSB = 19;
  localparam int ADDR_LSB = 16;
  localparam int DATA_MSB = 15;
  localparam int DATA_LSB = 4;
  localparam int REF_BIT = 0;
  localparam int MASK_B_BIT = 3;
  localparam int MASK_A_BIT = 0;
  localparam int CODE_W = 12;
  localparam int NUM_CH = 2;

  // ==========================================================================
  // Command codes
  localparam logic [3:0] CMD_WRITE_INPUT = 4'h1;
  localparam logic [3:0] CMD_UPDATE_DAC = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
  localparam logic [3:0] CMD_LOAD_MASK = 4'h5;
  localparam logic [3:0] CMD_SOFT_RESET = 4'h6;
  localparam logic [3:0] CMD_REF_SETUP = 4'h7;

  // ==========================================================================
  // Clear codes and reset values
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_MID = 12'h800;
  localparam logic REF_OFF_RESET = 1'b0;
  localparam logic [1:0] MASK_RESET = 2'h0;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
  } darc_frame_t;

  typedef struct packed {
    logic [11:0] ch_b;
    logic [11:0] ch_a;
  } darc_codes_t;
endpackage

// ---- rtl/darc_ctrl.sv ----
`timescale 1ns/1ps
module darc_ctrl (
  input wire logic clock,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic power_up_level_select,
  input wire logic output_load_strobe_n,
  input wire logic frame_valid,
  input wire darc_pkg::darc_frame_t frame,
  output darc_pkg::darc_codes_t dac_codes,
  output logic reference_off,
  output logic init_done
);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {DARC_POR, DARC_HELD, DARC_RUN} darc_state_t;

  darc_state_t state_r, state_nxt;
  logic [11:0] in_r [darc_pkg::NUM_CH];
  logic [11:0] in_nxt [darc_pkg::NUM_CH];
  logic [11:0] out_r [darc_pkg::NUM_CH];
  logic [11:0] out_nxt [darc_pkg::NUM_CH];
  logic [1:0] mask_r, mask_nxt;
  logic ref_off_r, ref_off_nxt;
  logic strobe_q_r;
  logic [11:0] clear_code;
  logic strobe_fall;
  logic accept;
  logic soft_rst;
  logic init_nxt;

  // Level select is sampled live, so reset_n and software reset use its current strap; rst loads CODE_ZERO
  assign clear_code = power_up_level_select ? darc_pkg::CODE_MID
                                            : darc_pkg::CODE_ZERO;
  assign strobe_fall = strobe_q_r && !output_load_strobe_n;
  // Frames arrive only after the last bit, so partial frames never strobe
  assign accept = frame_valid && reset_n && (state_r == DARC_RUN);
  assign soft_rst = accept && (frame.cmd == darc_pkg::CMD_SOFT_RESET);
  // A held reset pin reads as not initialised, even after power-up finished
  assign init_nxt = (state_nxt == DARC_RUN) && reset_n;

  // ==========================================================================
  // Initialisation sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      DARC_POR: begin
        state_nxt = reset_n ? DARC_RUN : DARC_HELD;
      end
      DARC_HELD: begin
        if (reset_n) begin
          state_nxt = DARC_RUN;
        end
      end
      default: begin
        state_nxt = DARC_RUN;
      end
    endcase
  end

  // ==========================================================================
  // Channel registers
  genvar g;
  generate
    for (g = 0; g < darc_pkg::NUM_CH; g++) begin : g_ch
      logic masked;
      logic addressed;
      assign masked = (g == 0) ? mask_r[0] : mask_r[1];
      assign addressed = frame.addr[g];

      always_comb begin
        in_nxt[g] = in_r[g];
        out_nxt[g] = out_r[g];
        if (state_r != DARC_RUN || !reset_n || soft_rst) begin
          in_nxt[g] = clear_code;
          out_nxt[g] = clear_code;
        end else begin
          if (accept && addressed) begin
            case (frame.cmd)
              darc_pkg::CMD_WRITE_INPUT: begin
                in_nxt[g] = frame.data[darc_pkg::DATA_MSB:darc_pkg::DATA_LSB];
                if (!output_load_strobe_n) begin
                  out_nxt[g] = frame.data[darc_pkg::DATA_MSB:darc_pkg::DATA_LSB];
                end
              end
              darc_pkg::CMD_UPDATE_DAC: begin
                out_nxt[g] = in_r[g];
              end
              darc_pkg::CMD_WRITE_UPDATE: begin
                in_nxt[g] = frame.data[darc_pkg::DATA_MSB:darc_pkg::DATA_LSB];
                out_nxt[g] = frame.data[darc_pkg::DATA_MSB:darc_pkg::DATA_LSB];
              end
              default: begin
              end
            endcase
          end else if (strobe_fall && !masked) begin
            out_nxt[g] = in_r[g];
          end
        end
      end

      always_ff @(posedge clock) begin
        if (rst) begin
          in_r[g] <= darc_pkg::CODE_ZERO;
          out_r[g] <= darc_pkg::CODE_ZERO;
        end else begin
          in_r[g] <= in_nxt[g];
          out_r[g] <= out_nxt[g];
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Mask and reference settings
  always_comb begin
    mask_nxt = mask_r;
    ref_off_nxt = ref_off_r;
    if (accept && frame.cmd == darc_pkg::CMD_LOAD_MASK) begin
      mask_nxt = {frame.data[darc_pkg::MASK_B_BIT], frame.data[darc_pkg::MASK_A_BIT]};
    end
    if (accept && frame.cmd == darc_pkg::CMD_REF_SETUP) begin
      // Address and don't-care fields deliberately unused
      ref_off_nxt = frame.data[darc_pkg::REF_BIT];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= DARC_POR;
      mask_r <= darc_pkg::MASK_RESET;
      ref_off_r <= darc_pkg::REF_OFF_RESET;
      strobe_q_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      mask_r <= mask_nxt;
      ref_off_r <= ref_off_nxt;
      // Forced high during power-on reset, so a strobe already low at release reads as a falling edge
      strobe_q_r <= output_load_strobe_n;
    end
  end

  // ==========================================================================
  // Outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      dac_codes <= '0;
      reference_off <= darc_pkg::REF_OFF_RESET;
      init_done <= 1'b0;
    end else begin
      dac_codes <= {out_nxt[1], out_nxt[0]};
      reference_off <= ref_off_nxt;
      init_done <= init_nxt;
    end
  end

  // ==========================================================================
  // Checks
  logic [11:0] frame_code;
  assign frame_code = frame.data[darc_pkg::DATA_MSB:darc_pkg::DATA_LSB];

  sequence s_por_release;
    $fell(rst) ##1 1'b1;
  endsequence

  sequence s_write_ch_b;
    accept && frame.cmd == darc_pkg::CMD_WRITE_UPDATE && frame.addr[1];
  endsequence

  // Strap is read live, so the expected clear code is the one of the loading edge
  a_reset_clears: assert property (@(posedge clock) disable iff (rst)
    !reset_n |=> dac_codes == {$past(clear_code), $past(clear_code)})
    else $error("outputs not cleared during reset");
  a_no_write_rst: assert property (@(posedge clock) disable iff (rst)
    !reset_n && !$past(reset_n) && !$past(rst) && $stable(power_up_level_select)
    |=> $stable(dac_codes))
    else $error("output changed while reset low");
  a_soft_reset: assert property (@(posedge clock) disable iff (rst)
    soft_rst |=> dac_codes == {$past(clear_code), $past(clear_code)})
    else $error("software reset did not clear");
  a_ref_only: assert property (@(posedge clock) disable iff (rst)
    accept && frame.cmd == darc_pkg::CMD_REF_SETUP |=> $stable(dac_codes))
    else $error("reference command touched outputs");
  a_ref_bit: assert property (@(posedge clock) disable iff (rst)
    accept && frame.cmd == darc_pkg::CMD_REF_SETUP
    |=> reference_off == $past(frame.data[darc_pkg::REF_BIT]))
    else $error("reference bit not applied");
  a_ref_hold: assert property (@(posedge clock) disable iff (rst)
    !(frame_valid && frame.cmd == darc_pkg::CMD_REF_SETUP) |=> $stable(reference_off))
    else $error("reference changed without frame");
  a_held_init: assert property (@(posedge clock) disable iff (rst)
    !reset_n |=> !init_done)
    else $error("initialised while reset low");
  a_strobe_load: assert property (@(posedge clock) disable iff (rst)
    strobe_fall && !mask_r[0] && !frame_valid && reset_n && init_done
    |=> dac_codes.ch_a == $past(in_r[0]))
    else $error("strobe did not load channel A");
  a_strobe_masked: assert property (@(posedge clock) disable iff (rst)
    strobe_fall && mask_r[0] && !frame_valid && reset_n && init_done
    |=> $stable(dac_codes.ch_a))
    else $error("masked channel A took strobe");
  a_write_update: assert property (@(posedge clock) disable iff (rst)
    s_write_ch_b |=> dac_codes.ch_b == $past(frame_code))
    else $error("write did not reach channel B");
  a_por_level: assert property (@(posedge clock)
    s_por_release |-> dac_codes == {$past(clear_code), $past(clear_code)})
    else $error("power-up level wrong");
  a_ref_default: assert property (@(posedge clock)
    s_por_release |-> !reference_off)
    else $error("reference not on after power-up");

endmodule

// ---- verif/darc_bus_master.sv ----
`timescale 1ns/1ps
// ==========================================================
// Serial bus master: hands over one complete frame per call
module darc_bus_master (
  input wire logic clock,
  output logic frame_valid,
  output darc_pkg::darc_frame_t frame
);
  initial begin
    frame_valid = 1'b0;
    frame = '0;
  end

  // Idle bus shows the inverted frame so stale data never looks valid
  task automatic send(input logic v, input darc_pkg::darc_frame_t f);
    @(negedge clock);
    frame_valid = v;
    frame = f;
    @(negedge clock);
    frame_valid = 1'b0;
    frame = ~f;
  endtask
endmodule

// ---- verif/test_dac_reset_and_reference_control.sv ----
`timescale 1ns/1ps
module test_dac_reset_and_reference_control;
  typedef struct packed {
    logic v;
    logic sel;
    logic [23:0] f;
    logic [23:0] codes;
    logic ref_off;
  } darc_row_t;
  logic clock = 1'b0, rst = 1'b1, reset_n = 1'b1, sel = 1'b0, ldn = 1'b1;
  logic frame_valid, reference_off, init_done;
  darc_pkg::darc_frame_t frame;
  darc_pkg::darc_codes_t codes;
  int n_fail = 0;
  int cmp_count = 0;
  darc_row_t rows [8] = '{
    '{1'b1, 1'b0, 24'h7f0001, 24'h000000, 1'b1},
    '{1'b0, 1'b0, 24'h700000, 24'h000000, 1'b1},
    '{1'b1, 1'b0, 24'h70fffe, 24'h000000, 1'b0},
    '{1'b1, 1'b0, 24'h11abc0, 24'h000000, 1'b0},
    '{1'b1, 1'b0, 24'h321230, 24'h123000, 1'b0},
    '{1'b1, 1'b0, 24'h210000, 24'h123abc, 1'b0},
    '{1'b1, 1'b1, 24'h600000, 24'h800800, 1'b0},
    '{1'b1, 1'b1, 24'h230000, 24'h800800, 1'b0}
  };

  initial forever #20 clock = ~clock;

  darc_bus_master m (.clock(clock), .frame_valid(frame_valid), .frame(frame));
  darc_ctrl dut_u (.clock(clock), .rst(rst), .reset_n(reset_n),
    .power_up_level_select(sel), .output_load_strobe_n(ldn),
    .frame_valid(frame_valid), .frame(frame), .dac_codes(codes),
    .reference_off(reference_off), .init_done(init_done));

  // ==========================================================
  // Checking
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Bounded wait; a hang ends the run at once
  task automatic wait_init();
    for (int i = 0; i < 8 && init_done !== 1'b1; i++) @(negedge clock);
    if (init_done !== 1'b1) begin
      n_fail++;
      $display("CHECK FAILED init_done expected 1 seen %b", init_done);
      give_verdict();
    end
  endtask

  task automatic step(input logic v, input logic [23:0] f);
    m.send(v, f);
    repeat (2) @(negedge clock);
  endtask

  // ==========================================================
  // Sequence
  initial begin
    repeat (16) begin
      @(negedge clock);
      ldn = ~ldn;
    end
    rst = 1'b0;
    wait_init();
    chk("codes", 24'h000000, codes);
    chk("ref_off", 24'h0, {23'h0, reference_off});
    foreach (rows[i]) begin
      sel = rows[i].sel;
      step(rows[i].v, rows[i].f);
      chk("codes", rows[i].codes, codes);
      chk("ref_off", {23'h0, rows[i].ref_off}, {23'h0, reference_off});
    end
    step(1'b1, 24'h135550);
    chk("codes", 24'h800800, codes);
    ldn = 1'b0;
    repeat (3) @(negedge clock);
    chk("codes", 24'h555555, codes);
    ldn = 1'b1;
    step(1'b1, 24'h500001);
    step(1'b1, 24'h136660);
    ldn = 1'b0;
    repeat (2) @(negedge clock);
    chk("codes", 24'h666555, codes);
    step(1'b1, 24'h117770);
    chk("codes", 24'h666777, codes);
    ldn = 1'b1;
    sel = 1'b0;
    reset_n = 1'b0;
    repeat (4) @(negedge clock);
    chk("codes", 24'h000000, codes);
    chk("init_done", 24'h0, {23'h0, init_done});
    step(1'b1, 24'h337770);
    ldn = 1'b0;
    repeat (2) @(negedge clock);
    chk("codes", 24'h000000, codes);
    ldn = 1'b1;
    reset_n = 1'b1;
    wait_init();
    step(1'b1, 24'h230000);
    chk("codes", 24'h000000, codes);
    rst = 1'b1;
    reset_n = 1'b0;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    chk("init_done", 24'h0, {23'h0, init_done});
    sel = 1'b1;
    reset_n = 1'b1;
    wait_init();
    chk("codes", 24'h800800, codes);
    give_verdict();
  end
endmodule
